// file: shared/brs_pkg.sv
// constants, register map and state encoding of the breaker reclose sequencer
// assumes a single 10 MHz clock and a one-clock line-cycle tick from outside
package brs_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;

  // register map, byte addresses on the apb bus
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_OI_ONE   = 8'h04;
  localparam logic [7:0] OFF_OI_TWO   = 8'h08;
  localparam logic [7:0] OFF_OI_THREE = 8'h0c;
  localparam logic [7:0] OFF_OI_FOUR  = 8'h10;
  localparam logic [7:0] OFF_RST_INT  = 8'h14;
  localparam logic [7:0] OFF_MASK     = 8'h18;
  localparam logic [7:0] OFF_PICKUP   = 8'h1c;
  localparam logic [7:0] OFF_TRIPLEN  = 8'h20;
  localparam logic [7:0] OFF_STATUS   = 8'h24;

  // field widths
  localparam int unsigned TMR_W  = 16;
  localparam int unsigned CUR_W  = 16;
  localparam int unsigned MASK_W = 5;
  localparam int unsigned LEN_W  = 8;
  localparam int unsigned SHOT_W = 3;

  // control register bits
  localparam int unsigned CTRL_CLOSE_BIT   = 0;
  localparam int unsigned CTRL_TRIPSEL_BIT = 1;

  // status register fields
  localparam int unsigned ST_RESET_BIT   = 0;
  localparam int unsigned ST_CYCLE_BIT   = 1;
  localparam int unsigned ST_LOCKOUT_BIT = 2;
  localparam int unsigned ST_SHOT_LSB    = 4;
  localparam int unsigned ST_TRIP_BIT    = 8;
  localparam int unsigned ST_CLOSE_BIT   = 9;
  localparam int unsigned ST_MATCH_BIT   = 10;

  // reset values, line cycles and hundredths of an ampere
  localparam logic [31:0]       RST_CTRL    = 32'h0000_0002;
  localparam logic [TMR_W-1:0]  RST_OI_ONE  = 16'h003c;
  localparam logic [TMR_W-1:0]  RST_OI_TWO  = 16'h0258;
  localparam logic [TMR_W-1:0]  RST_OI_THR  = 16'h0384;
  localparam logic [TMR_W-1:0]  RST_OI_FOUR = 16'h0000;
  localparam logic [TMR_W-1:0]  RST_RST_INT = 16'h0708;
  localparam logic [MASK_W-1:0] RST_MASK    = 5'h0a;
  localparam logic [CUR_W-1:0]  RST_PICKUP  = 16'h0190;
  localparam logic [LEN_W-1:0]  RST_TRIPLEN = 8'h04;

  localparam logic [SHOT_W-1:0] MAX_SHOTS = 3'h4;

  typedef enum logic [2:0] {
    ST_RESET   = 3'b001,
    ST_CYCLE   = 3'b010,
    ST_LOCKOUT = 3'b100
  } brs_state_type;

endpackage

// file: rtl/brs_cycle_timer.sv
// line-cycle interval timer: counts ticks while run is high
// assumes tick is a one-clock pulse per power-line cycle
module brs_cycle_timer (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        resetn,
  // control
  input  wire logic                        run,
  input  wire logic                        tick,
  input  wire logic [brs_pkg::TMR_W-1:0]   limit,
  // result
  output logic                             expired
);
  import brs_pkg::*;

  logic [TMR_W-1:0] cnt_r;
  logic [TMR_W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (!run) begin
      cnt_nxt = '0;
    end else if (tick && cnt_r != limit) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign expired = run && (cnt_r == limit);

endmodule

// file: rtl/brs_apb_regs.sv
// apb slave holding the sequencer settings and showing its status
// assumes apb3 signalling; one wait state on every access
module brs_apb_regs (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          resetn,
  // apb
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [brs_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic                               pready,
  output logic [31:0]                        prdata,
  output logic                               pslverr,
  // settings
  output logic                               close_cmd,
  output logic                               trip_sel,
  output logic [brs_pkg::TMR_W-1:0]          first_open_interval,
  output logic [brs_pkg::TMR_W-1:0]          second_open_interval,
  output logic [brs_pkg::TMR_W-1:0]          third_open_interval,
  output logic [brs_pkg::TMR_W-1:0]          fourth_open_interval,
  output logic [brs_pkg::TMR_W-1:0]          reset_interval_setting,
  output logic [brs_pkg::MASK_W-1:0]         shot_select_mask,
  output logic [brs_pkg::CUR_W-1:0]          pickup_level,
  output logic [brs_pkg::LEN_W-1:0]          trip_pulse_length,
  // status
  input  wire logic [31:0]                   status_word
);
  import brs_pkg::*;

  logic        wr_go;
  logic        rd_go;
  logic        hit;
  logic [31:0] rd_val;
  logic        pready_nxt;
  logic        cmd_nxt;

  assign wr_go = psel && penable && pready && pwrite;
  assign rd_go = psel && penable && !pready;

  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      OFF_CTRL:     rd_val[CTRL_TRIPSEL_BIT] = trip_sel;
      OFF_OI_ONE:   rd_val[TMR_W-1:0] = first_open_interval;
      OFF_OI_TWO:   rd_val[TMR_W-1:0] = second_open_interval;
      OFF_OI_THREE: rd_val[TMR_W-1:0] = third_open_interval;
      OFF_OI_FOUR:  rd_val[TMR_W-1:0] = fourth_open_interval;
      OFF_RST_INT:  rd_val[TMR_W-1:0] = reset_interval_setting;
      OFF_MASK:     rd_val[MASK_W-1:0] = shot_select_mask;
      OFF_PICKUP:   rd_val[CUR_W-1:0] = pickup_level;
      OFF_TRIPLEN:  rd_val[LEN_W-1:0] = trip_pulse_length;
      OFF_STATUS:   rd_val = status_word;
      default:      hit = 1'b0;
    endcase
    pready_nxt = psel && penable && !pready;
    cmd_nxt    = wr_go && hit && (paddr == OFF_CTRL) && pwdata[CTRL_CLOSE_BIT];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready                 <= 1'b0;
      prdata                 <= 32'h0000_0000;
      pslverr                <= 1'b0;
      close_cmd              <= 1'b0;
      trip_sel               <= RST_CTRL[CTRL_TRIPSEL_BIT];
      first_open_interval    <= RST_OI_ONE;
      second_open_interval   <= RST_OI_TWO;
      third_open_interval    <= RST_OI_THR;
      fourth_open_interval   <= RST_OI_FOUR;
      reset_interval_setting <= RST_RST_INT;
      shot_select_mask       <= RST_MASK;
      pickup_level           <= RST_PICKUP;
      trip_pulse_length      <= RST_TRIPLEN;
    end else begin
      pready    <= pready_nxt;
      close_cmd <= cmd_nxt;
      if (rd_go) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_val;
        pslverr <= !hit;
      end
      if (wr_go) begin
        case (paddr)
          OFF_CTRL:     trip_sel <= pwdata[CTRL_TRIPSEL_BIT];
          OFF_OI_ONE:   first_open_interval <= pwdata[TMR_W-1:0];
          OFF_OI_TWO:   second_open_interval <= pwdata[TMR_W-1:0];
          OFF_OI_THREE: third_open_interval <= pwdata[TMR_W-1:0];
          OFF_OI_FOUR:  fourth_open_interval <= pwdata[TMR_W-1:0];
          OFF_RST_INT:  reset_interval_setting <= pwdata[TMR_W-1:0];
          OFF_MASK:     shot_select_mask <= pwdata[MASK_W-1:0];
          OFF_PICKUP:   pickup_level <= pwdata[CUR_W-1:0];
          OFF_TRIPLEN:  trip_pulse_length <= pwdata[LEN_W-1:0];
          default:      trip_sel <= trip_sel;
        endcase
      end
    end
  end

endmodule

// file: rtl/brs_sequencer.sv
// multiple-shot automatic reclose sequencer for one circuit breaker
// assumes inputs synchronous to clk and line_tick one clock per line cycle
//
// Function
// - go to reset after breaker stays closed for the reset interval
// - reset interval timer starts when breaker closed status asserts
// - reset timer expiry sets reset bit and clears lockout bit
// - lockout holds after a close until the reset timer expires
// - open timer runs with breaker open, trip dropped, intervals left
// - open timer reaching its setting asserts the close output
// - four open intervals in order; a zero ends the sequence there
// - a retrip before reset expiry uses the next open interval
// - three intervals give three recloses, then lockout on fourth trip
// - first trip in reset clears reset bit, sets cycle bit
// - cycle returns to reset when breaker stays closed for reset interval
// - cycle goes to lockout when no intervals remain and breaker open
// - reclose enable low forces lockout at once
// - breaker opening without a trip puts the sequencer in lockout
// - reset, cycle and lockout indicators mirror the state bits
// - selected pickup element over threshold asserts trip at once
// - direct close input or close command asserts the close output
// - open timer expiry increments shot count; shot is zero in reset
// - shot match bit follows the mask position of the current shot
//
// Local design decisions: the APB interface to the registers and the register addresses.
module brs_sequencer (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        resetn,
  // apb register port
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [brs_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic                             pready,
  output logic [31:0]                      prdata,
  output logic                             pslverr,
  // line and breaker inputs
  input  wire logic                        line_tick,
  input  wire logic [brs_pkg::CUR_W-1:0]   phase_current,
  input  wire logic                        breaker_closed_status,
  input  wire logic                        reclose_enable_input,
  input  wire logic                        direct_close_input,
  // breaker coils
  output logic                             trip_out,
  output logic                             close_out,
  // state bits
  output logic                             reset_state_bit,
  output logic                             cycle_state_bit,
  output logic                             lockout_state_bit,
  output logic                             shot_match_bit,
  // front indicators
  output logic                             reset_led,
  output logic                             cycle_led,
  output logic                             lockout_led,
  // programmable outputs
  output logic                             programmable_output_one,
  output logic                             programmable_output_two,
  output logic                             programmable_output_three,
  output logic                             programmable_output_four
);
  import brs_pkg::*;

  // settings from the register file
  logic              close_cmd;
  logic              trip_sel;
  logic [TMR_W-1:0]  first_open_interval;
  logic [TMR_W-1:0]  second_open_interval;
  logic [TMR_W-1:0]  third_open_interval;
  logic [TMR_W-1:0]  fourth_open_interval;
  logic [TMR_W-1:0]  reset_interval_setting;
  logic [MASK_W-1:0] shot_select_mask;
  logic [CUR_W-1:0]  pickup_level;
  logic [LEN_W-1:0]  trip_pulse_length;
  logic [31:0]       status_word;

  // sequencer state
  brs_state_type     state_r;
  brs_state_type     state_nxt;
  logic [SHOT_W-1:0] shot_r;
  logic [SHOT_W-1:0] shot_nxt;
  logic              trip_r;
  logic              trip_nxt;
  logic [LEN_W-1:0]  hold_r;
  logic [LEN_W-1:0]  hold_nxt;
  logic              close_r;
  logic              close_nxt;
  logic              closed_prev_r;
  logic              match_r;
  logic              match_nxt;

  // decoded conditions
  logic              phase_pickup_element;
  logic              trip_event;
  logic              manual_open;
  logic [TMR_W-1:0]  oi_limit;
  logic              oi_avail;
  logic              run_reset;
  logic              run_open;
  logic              reset_exp;
  logic              open_exp;
  logic              breaker_idle_open;

  brs_apb_regs u_regs (
    .clk                    (clk),
    .resetn                 (resetn),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .pready                 (pready),
    .prdata                 (prdata),
    .pslverr                (pslverr),
    .close_cmd              (close_cmd),
    .trip_sel               (trip_sel),
    .first_open_interval    (first_open_interval),
    .second_open_interval   (second_open_interval),
    .third_open_interval    (third_open_interval),
    .fourth_open_interval   (fourth_open_interval),
    .reset_interval_setting (reset_interval_setting),
    .shot_select_mask       (shot_select_mask),
    .pickup_level           (pickup_level),
    .trip_pulse_length      (trip_pulse_length),
    .status_word            (status_word)
  );

  // reset interval: runs while breaker closed outside the reset state
  brs_cycle_timer u_reset_timer (
    .clk     (clk),
    .resetn  (resetn),
    .run     (run_reset),
    .tick    (line_tick),
    .limit   (reset_interval_setting),
    .expired (reset_exp)
  );

  // open interval: one setting per shot
  brs_cycle_timer u_open_timer (
    .clk     (clk),
    .resetn  (resetn),
    .run     (run_open),
    .tick    (line_tick),
    .limit   (oi_limit),
    .expired (open_exp)
  );

  // trip decision and event detection
  always_comb begin
    phase_pickup_element = phase_current > pickup_level;
    trip_event  = trip_sel && phase_pickup_element && !trip_r;
    manual_open = closed_prev_r && !breaker_closed_status
                  && !trip_r && !trip_event;
  end

  // open interval selection by shot count
  always_comb begin
    case (shot_r)
      3'h0:    oi_limit = first_open_interval;
      3'h1:    oi_limit = second_open_interval;
      3'h2:    oi_limit = third_open_interval;
      3'h3:    oi_limit = fourth_open_interval;
      default: oi_limit = '0;
    endcase
    // a zero setting hides itself and all later ones
    oi_avail = (shot_r < MAX_SHOTS) && (oi_limit != '0);
  end

  // timer run conditions
  always_comb begin
    breaker_idle_open = !breaker_closed_status && !trip_r && !close_r;
    run_reset = breaker_closed_status && (state_r != ST_RESET);
    run_open  = (state_r == ST_CYCLE) && breaker_idle_open
                && oi_avail;
  end

  // trip output with minimum length in line cycles
  always_comb begin
    trip_nxt = trip_r;
    hold_nxt = hold_r;
    if (trip_sel && phase_pickup_element) begin
      trip_nxt = 1'b1;
      hold_nxt = '0;
    end else if (trip_r) begin
      if (hold_r >= trip_pulse_length) begin
        trip_nxt = 1'b0;
        hold_nxt = '0;
      end else if (line_tick) begin
        hold_nxt = hold_r + 8'h01;
      end
    end
  end

  // close output: sealed in until the breaker reports closed or a trip is issued
  always_comb begin
    close_nxt = close_r;
    if (breaker_closed_status || trip_nxt) begin
      close_nxt = 1'b0;
    end
    if (direct_close_input || close_cmd) begin
      close_nxt = 1'b1;
    end
    if (open_exp && state_r == ST_CYCLE && reclose_enable_input) begin
      close_nxt = 1'b1;
    end
  end

  // state sequence and shot counter
  always_comb begin
    state_nxt = state_r;
    shot_nxt  = shot_r;
    if (!reclose_enable_input) begin
      state_nxt = ST_LOCKOUT;
    end else begin
      case (state_r)
        ST_RESET: begin
          shot_nxt = '0;
          if (trip_event) begin
            state_nxt = ST_CYCLE;
          end else if (manual_open) begin
            state_nxt = ST_LOCKOUT;
          end
        end
        ST_CYCLE: begin
          if (reset_exp) begin
            state_nxt = ST_RESET;
            shot_nxt  = '0;
          end else if (manual_open) begin
            state_nxt = ST_LOCKOUT;
          end else if (breaker_idle_open && !oi_avail) begin
            state_nxt = ST_LOCKOUT;
          end else if (open_exp) begin
            shot_nxt = shot_r + 3'h1;
          end
        end
        ST_LOCKOUT: begin
          if (reset_exp) begin
            state_nxt = ST_RESET;
            shot_nxt  = '0;
          end
        end
        default: begin
          state_nxt = ST_LOCKOUT;
          shot_nxt  = '0;
        end
      endcase
    end
    match_nxt = shot_select_mask[shot_nxt];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r       <= ST_LOCKOUT;
      shot_r        <= '0;
      trip_r        <= 1'b0;
      hold_r        <= '0;
      close_r       <= 1'b0;
      closed_prev_r <= 1'b0;
      match_r       <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      shot_r        <= shot_nxt;
      trip_r        <= trip_nxt;
      hold_r        <= hold_nxt;
      close_r       <= close_nxt;
      closed_prev_r <= breaker_closed_status;
      match_r       <= match_nxt;
    end
  end

  // outputs, all registered from the same next values
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trip_out                  <= 1'b0;
      close_out                 <= 1'b0;
      reset_state_bit           <= 1'b0;
      cycle_state_bit           <= 1'b0;
      lockout_state_bit         <= 1'b1;
      shot_match_bit            <= 1'b0;
      reset_led                 <= 1'b0;
      cycle_led                 <= 1'b0;
      lockout_led               <= 1'b1;
      programmable_output_one   <= 1'b0;
      programmable_output_two   <= 1'b0;
      programmable_output_three <= 1'b1;
      programmable_output_four  <= 1'b0;
    end else begin
      trip_out                  <= trip_nxt;
      close_out                 <= close_nxt;
      reset_state_bit           <= state_nxt == ST_RESET;
      cycle_state_bit           <= state_nxt == ST_CYCLE;
      lockout_state_bit         <= state_nxt == ST_LOCKOUT;
      shot_match_bit            <= match_nxt;
      reset_led                 <= state_nxt == ST_RESET;
      cycle_led                 <= state_nxt == ST_CYCLE;
      lockout_led               <= state_nxt == ST_LOCKOUT;
      programmable_output_one   <= state_nxt == ST_RESET;
      programmable_output_two   <= state_nxt == ST_CYCLE;
      programmable_output_three <= state_nxt == ST_LOCKOUT;
      programmable_output_four  <= match_nxt;
    end
  end

  // status word for software
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_RESET_BIT]   = state_r == ST_RESET;
    status_word[ST_CYCLE_BIT]   = state_r == ST_CYCLE;
    status_word[ST_LOCKOUT_BIT] = state_r == ST_LOCKOUT;
    status_word[ST_SHOT_LSB +: SHOT_W] = shot_r;
    status_word[ST_TRIP_BIT]    = trip_r;
    status_word[ST_CLOSE_BIT]   = close_r;
    status_word[ST_MATCH_BIT]   = match_r;
  end

endmodule

// file: verification/brs_breaker_model.sv
// breaker simulator: a latching contact worked by the trip and close coils
// assumes coil levels from the sequencer on the same clock
module brs_breaker_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // coils and operator
  input  wire logic trip_out,
  input  wire logic close_out,
  input  wire logic manual_open,
  input  wire logic slow,
  // auxiliary contact
  output logic      breaker_closed_status
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] lag_r;
  // slow mechanism needs the close coil held for four clocks
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      breaker_closed_status <= 1'b0;
      lag_r <= 2'h0;
    end else begin
      lag_r <= close_out ? lag_r + 2'h1 : 2'h0;
      if (trip_out || manual_open) breaker_closed_status <= 1'b0;
      else if (close_out && (!slow || lag_r == 2'h3)) breaker_closed_status <= 1'b1;
    end
  end
endmodule

// file: verification/brs_sequencer_properties.sv
// port assertions of the reclose sequencer
// assumes one clock domain and the asynchronous active-low reset
module brs_sequencer_properties (
  // clock, reset and breaker side
  input wire logic clk,
  input wire logic resetn,
  input wire logic breaker_closed_status,
  input wire logic reclose_enable_input,
  input wire logic direct_close_input,
  input wire logic trip_out,
  input wire logic close_out,
  // state bits and their copies
  input wire logic reset_state_bit,
  input wire logic cycle_state_bit,
  input wire logic lockout_state_bit,
  input wire logic shot_match_bit,
  input wire logic reset_led,
  input wire logic cycle_led,
  input wire logic lockout_led,
  input wire logic programmable_output_one,
  input wire logic programmable_output_two,
  input wire logic programmable_output_three,
  input wire logic programmable_output_four
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_first_trip;
    reset_state_bit && !trip_out && reclose_enable_input ##1 trip_out;
  endsequence
  sequence s_quiet_open;
    reset_state_bit && breaker_closed_status && !trip_out && !close_out ##1 !breaker_closed_status && !trip_out;
  endsequence
  a_led_mirror: assert property ({reset_led, cycle_led, lockout_led} ==
    {reset_state_bit, cycle_state_bit, lockout_state_bit}) else $error("led differs");
  a_output_map: assert property ({programmable_output_one, programmable_output_two,
    programmable_output_three, programmable_output_four} == {reset_state_bit, cycle_state_bit,
    lockout_state_bit, shot_match_bit}) else $error("programmable output differs");
  a_trip_enters_cycle: assert property (s_first_trip |-> cycle_state_bit && !reset_state_bit)
    else $error("no cycle on trip");
  a_enable_low_lockout: assert property (!reclose_enable_input |=> lockout_state_bit)
    else $error("disable did not lock out");
  a_direct_close: assert property (direct_close_input && !trip_out && !breaker_closed_status
    |=> close_out) else $error("direct close ignored");
  a_reset_needs_closed: assert property (!reset_state_bit ##1 reset_state_bit |->
    $past(breaker_closed_status)) else $error("reset entered with breaker open");
  a_lockout_exit: assert property ($fell(lockout_state_bit) |-> reset_state_bit)
    else $error("lockout left other than to reset");
  a_cycle_to_lockout: assert property ($fell(cycle_state_bit) && lockout_state_bit |->
    !$past(breaker_closed_status) || !$past(reclose_enable_input)) else $error("lockout with breaker closed");
  a_cycle_to_reset: assert property ($fell(cycle_state_bit) && reset_state_bit |->
    $past(breaker_closed_status)) else $error("reset from cycle with breaker open");
  a_quiet_open: assert property (s_quiet_open |=> lockout_state_bit)
    else $error("untripped opening not locked out");
endmodule
bind brs_sequencer brs_sequencer_properties i_brs_sequencer_properties (.*);

// file: verification/brs_sequencer_bench.sv
// self-checking bench of the reclose sequencer with a breaker simulator
// assumes apb with one wait state and a line tick every fourth clock
module brs_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import brs_pkg::*;
  logic              clk, resetn, psel, penable, pwrite, pready, pslverr, line_tick;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic [CUR_W-1:0]  phase_current;
  logic              breaker_closed_status, reclose_enable_input, direct_close_input, trip_out, close_out;
  logic              reset_state_bit, cycle_state_bit, lockout_state_bit, shot_match_bit;
  logic              reset_led, cycle_led, lockout_led, manual_open, slow;
  logic              programmable_output_one, programmable_output_two;
  logic              programmable_output_three, programmable_output_four;
  logic [1:0]        div_r = 2'h0;
  int                bad_count, checks_done;
  brs_sequencer i_brs_sequencer (.*);
  brs_breaker_model i_brs_breaker_model (.*);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    div_r <= div_r + 2'h1;
    line_tick <= (div_r == 2'h3);
  end
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task fail;
    bad_count++;
    conclude;
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) fail;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // mode 0 reset, 1 close, 2 lockout; n counts timed ticks
  task ticks_until(input int mode, output int n);
    n = 0;
    for (int k = 0; k < 4000; k++) begin
      @(posedge clk);
      if (mode == 0 && reset_state_bit || mode == 1 && close_out || mode == 2 && lockout_state_bit) return;
      if (line_tick && (mode == 0 ? breaker_closed_status : !breaker_closed_status && !trip_out)) n++;
    end
    fail;
  endtask
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    logic [7:0] offs[5] = '{OFF_OI_ONE, OFF_OI_TWO, OFF_OI_THREE, OFF_OI_FOUR, OFF_RST_INT};
    logic [15:0] vals[5] = '{16'h0003, 16'h0005, 16'h0007, 16'h0000, 16'h0014};
    apb(1'b0, OFF_OI_ONE, 32'h0, q, e);
    chk("first interval", q, {16'h0, RST_OI_ONE});
    apb(1'b0, OFF_RST_INT, 32'h0, q, e);
    chk("reset interval", q, {16'h0, RST_RST_INT});
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk("unmapped error", {31'h0, e}, 32'h1);
    for (int i = 0; i < 5; i++) apb(1'b1, offs[i], {16'h0, vals[i]}, q, e);
    apb(1'b1, OFF_STATUS, 32'hffff, q, e);
    apb(1'b0, OFF_STATUS, 32'h0, q, e);
    chk("status after reset", q, 32'h4);
    $display("test regs done");
  endtask
  task t_close_reset;
    int n;
    direct_close_input <= 1'b1;
    ticks_until(1, n);
    direct_close_input <= 1'b0;
    chk("lockout while timing", lockout_state_bit, 1'b1);
    ticks_until(0, n);
    chk("reset ticks", n, 20);
    chk("lockout cleared", lockout_state_bit, 1'b0);
    $display("test close to reset done");
  endtask
  task automatic t_shots;
    int n;
    logic [31:0] q;
    logic e;
    int iv[3] = '{3, 5, 7};
    for (int i = 0; i < 4; i++) begin
      phase_current <= 16'h01f4;
      repeat (2) @(posedge clk);
      chk("trip", trip_out, 1'b1);
      chk("cycle", cycle_state_bit, 1'b1);
      phase_current <= 16'h0000;
      ticks_until(i < 3 ? 1 : 2, n);
      if (i < 3) begin
        chk("open ticks", n, iv[i]);
        repeat (3) @(posedge clk);
        chk("shot match", shot_match_bit, RST_MASK[i+1]);
      end
    end
    chk("no fourth close", close_out, 1'b0);
    apb(1'b0, OFF_STATUS, 32'h0, q, e);
    chk("shot held", q[6:4], 3'h3);
    $display("test shots done");
  endtask
  task t_cycle_reset;
    int n;
    logic [31:0] q;
    logic e;
    slow <= 1'b1;
    apb(1'b1, OFF_CTRL, 32'h3, q, e);
    ticks_until(1, n);
    ticks_until(0, n);
    chk("slow close reset ticks", n, 20);
    phase_current <= 16'h01f4;
    repeat (2) @(posedge clk);
    phase_current <= 16'h0000;
    ticks_until(1, n);
    chk("first interval again", n, 3);
    ticks_until(0, n);
    chk("cycle reset ticks", n, 20);
    apb(1'b0, OFF_STATUS, 32'h0, q, e);
    chk("shot cleared", q[6:4], 3'h0);
    slow <= 1'b0;
    $display("test cycle reset done");
  endtask
  task t_enable_manual;
    int n;
    logic [31:0] q;
    logic e;
    reclose_enable_input <= 1'b0;
    repeat (2) @(posedge clk);
    chk("disable lockout", lockout_state_bit, 1'b1);
    reclose_enable_input <= 1'b1;
    ticks_until(0, n);
    manual_open <= 1'b1;
    repeat (3) @(posedge clk);
    chk("manual open lockout", lockout_state_bit, 1'b1);
    manual_open <= 1'b0;
    apb(1'b1, OFF_CTRL, 32'h0, q, e);
    phase_current <= 16'h01f4;
    repeat (2) @(posedge clk);
    chk("unselected trip", trip_out, 1'b0);
    phase_current <= 16'h0000;
    $display("test enable and manual open done");
  endtask
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {phase_current, direct_close_input, manual_open, slow} = '0;
    reclose_enable_input = 1'b1;
    bad_count = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_regs;
    t_close_reset;
    t_shots;
    t_cycle_reset;
    t_enable_manual;
    conclude;
  end
endmodule
